// File: design/led_ctrl_pkg.sv
// Constants, register map and carrier types of the port status lamp controller.
// Assumes a 250 MHz pclk domain and an APB master with 32-bit data.
package led_ctrl_pkg;
  // ----------------------------------------
  // Port counts and activity vector layout
  // ----------------------------------------
  localparam int N_CU = 4;
  localparam int N_FX = 4;
  localparam int N_GC = 2;
  localparam int N_GF = 2;
  localparam int N_ACT = 12;
  localparam int ACT_CU = 0;
  localparam int ACT_FX = 4;
  localparam int ACT_GC = 8;
  localparam int ACT_GF = 10;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CU_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GIG_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CU_AN_DIS_LSB = 0;
  localparam int CU_F100_LSB = 4;
  localparam int CU_FFULL_LSB = 8;
  localparam int CU_AX_DIS_LSB = 12;
  localparam int GF_MAN_LSB = 0;
  localparam int GC_MAN_LSB = 2;
  localparam int ST_CU_LSB = 0;
  localparam int ST_FX_LSB = 4;
  localparam int ST_GC_LSB = 8;
  localparam int ST_GF_LSB = 10;
  localparam int ST_TROUBLE = 12;
  localparam int ST_PD_LSB = 16;
  localparam int ST_CU100_LSB = 20;
  localparam int ST_CUFULL_LSB = 24;
  localparam int IRQ_W = 13;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] CU_CTRL_RST = 16'h0000;
  localparam logic [3:0] GIG_CTRL_RST = 4'h0;
  localparam logic [12:0] IRQ_MASK_RST = 13'h0000;
  // ----------------------------------------
  // Gigabit copper speed code
  // ----------------------------------------
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int BLINK_HALF_US = 40000;
  localparam int BLINK_HALF_CYC = BLINK_HALF_US * CLK_MHZ;
  localparam int BLINK_CNT_W = 24;
  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic link;
    logic spd100;
    logic rx_act;
    logic partner_an;
    logic partner_100;
    logic partner_full;
    logic idle_100;
  } copper_phy_t;
  typedef struct packed {
    logic link;
    logic full;
    logic rx_act;
  } fibre100_t;
  typedef struct packed {
    logic link;
    logic [1:0] speed;
    logic rx_act;
  } gig_cu_t;
  typedef struct packed {
    logic link;
    logic rx_act;
  } gig_fx_t;
  typedef struct packed {
    logic sig_ok;
    logic drawing;
  } poe_port_t;
endpackage

// File: design/port_status_led_controller.sv
// Port status lamp controller: lamps, PoE power enables, copper negotiation.
// Assumes all PHY and PoE status pins are asynchronous to pclk.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps
// Function
// - Copper port lamp steady on 10/100 link
// - Lamps blink on receive, not transmit
// - Gigabit copper 1000: upper lamp only
// - Gigabit copper 10: lower lamp only
// - Gigabit copper 100: both lamps
// - Fibre 100 lamp: link on, receive blink
// - Fibre 100 duplex lamp on when full
// - Gigabit fibre lamp: link on, receive blink
// - PD lamp only while device draws power
// - Non-PoE device: lamp off, no power
// - No PoE input power: all PD lamps on
// - Data path independent of PoE state
// - Copper default auto; software may force
// - Gigabit fibre leaves reset in auto
// - Gigabit copper defaults to automatic speed
// - Non-negotiating partner: idle speed, half duplex
module port_status_led_controller #(
  parameter int BLINK_HALF = led_ctrl_pkg::BLINK_HALF_CYC
) (
  input wire logic pclk, // Switch logic clock
  input wire logic presetn, // Async reset
  input wire logic clk_en, // Freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire led_ctrl_pkg::copper_phy_t [3:0] cu_phy, // Copper 10/100 PHY status
  input wire led_ctrl_pkg::fibre100_t [3:0] fx_phy, // Fibre 100 status
  input wire led_ctrl_pkg::gig_cu_t [1:0] gc_phy, // Gigabit copper status
  input wire led_ctrl_pkg::gig_fx_t [1:0] gf_phy, // Gigabit fibre status
  input wire led_ctrl_pkg::poe_port_t [3:0] poe_in, // PoE detection per port
  input wire logic poe_input_ok, // PoE input power present
  output logic [3:0] cu_led, // Copper link/activity lamps
  output logic [3:0] pd_led, // Powered-device lamps
  output logic [3:0] poe_pwr_en, // PoE power sourcing enables
  output logic [1:0] gc_led_top, // Gigabit copper upper lamps
  output logic [1:0] gc_led_bot, // Gigabit copper lower lamps
  output logic [3:0] fx_la_led, // Fibre 100 link/activity lamps
  output logic [3:0] fx_fd_led, // Fibre 100 duplex lamps
  output logic [1:0] gf_led, // Gigabit fibre lamps
  output logic [3:0] cu_an_en, // Copper negotiation enables
  output logic [3:0] automatic_crossover, // Copper crossover enables
  output logic [3:0] cu_mode_100, // Copper resolved speed 100
  output logic [3:0] cu_mode_full, // Copper resolved full duplex
  output logic [1:0] gc_auto, // Gigabit copper auto speed
  output logic [1:0] gf_auto, // Gigabit fibre auto mode
  output logic irq // Level interrupt
);
  import led_ctrl_pkg::*;

  localparam logic [BLINK_CNT_W-1:0] BLINK_LAST = BLINK_CNT_W'(BLINK_HALF - 1);

  function automatic logic lamp(input logic on, input logic blink, input logic dark);
    lamp = on & ~(blink & dark);
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  copper_phy_t [3:0] cu_s1_q, cu_q;
  fibre100_t [3:0] fx_s1_q, fx_q;
  gig_cu_t [1:0] gc_s1_q, gc_q;
  gig_fx_t [1:0] gf_s1_q, gf_q;
  poe_port_t [3:0] poe_s1_q, poe_q;
  logic pin_ok_s1_q, pin_ok_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cu_s1_q <= '0;
      cu_q <= '0;
      fx_s1_q <= '0;
      fx_q <= '0;
      gc_s1_q <= '0;
      gc_q <= '0;
      gf_s1_q <= '0;
      gf_q <= '0;
      poe_s1_q <= '0;
      poe_q <= '0;
    end else if (clk_en) begin
      cu_s1_q <= cu_phy;
      cu_q <= cu_s1_q;
      fx_s1_q <= fx_phy;
      fx_q <= fx_s1_q;
      gc_s1_q <= gc_phy;
      gc_q <= gc_s1_q;
      gf_s1_q <= gf_phy;
      gf_q <= gf_s1_q;
      poe_s1_q <= poe_in;
      poe_q <= poe_s1_q;
    end
  end

  // Power-good sync resets to present, so neither a false trouble
  // event nor a flash of every PD lamp follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ok_s1_q <= 1'b1;
      pin_ok_q <= 1'b1;
    end else if (clk_en) begin
      pin_ok_s1_q <= poe_input_ok;
      pin_ok_q <= pin_ok_s1_q;
    end
  end

  // ----------------------------------------
  // Blink timer
  // ----------------------------------------
  logic [BLINK_CNT_W-1:0] blink_cnt_q;
  logic dark_q;
  logic period_start;

  assign period_start = clk_en && (blink_cnt_q == BLINK_LAST) && dark_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_q <= '0;
      dark_q <= 1'b0;
    end else if (clk_en) begin
      if (blink_cnt_q == BLINK_LAST) begin
        blink_cnt_q <= '0;
        dark_q <= ~dark_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Receive activity stretching
  // ----------------------------------------
  logic [N_ACT-1:0] act_now, link_now;
  logic [N_ACT-1:0] act_seen_q, blinking_q;

  always_comb begin
    for (int i = 0; i < N_CU; i++) begin
      act_now[ACT_CU+i] = cu_q[i].rx_act;
      link_now[ACT_CU+i] = cu_q[i].link;
    end
    for (int i = 0; i < N_FX; i++) begin
      act_now[ACT_FX+i] = fx_q[i].rx_act;
      link_now[ACT_FX+i] = fx_q[i].link;
    end
    for (int i = 0; i < N_GC; i++) begin
      act_now[ACT_GC+i] = gc_q[i].rx_act;
      link_now[ACT_GC+i] = gc_q[i].link;
    end
    for (int i = 0; i < N_GF; i++) begin
      act_now[ACT_GF+i] = gf_q[i].rx_act;
      link_now[ACT_GF+i] = gf_q[i].link;
    end
  end

  // Activity held until the next full period, so a single frame is visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_seen_q <= '0;
      blinking_q <= '0;
    end else if (clk_en) begin
      if (period_start) begin
        blinking_q <= act_seen_q | act_now;
        act_seen_q <= act_now;
      end else begin
        act_seen_q <= act_seen_q | act_now;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] cu_ctrl_q;
  logic [3:0] gig_ctrl_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;
  logic [IRQ_W-1:0] link_prev_q;
  logic trouble;
  logic wr_fire, acc;
  logic [31:0] status_word;

  assign trouble = ~pin_ok_q;
  assign acc = psel && penable;
  assign wr_fire = clk_en && acc && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cu_ctrl_q <= CU_CTRL_RST;
      gig_ctrl_q <= GIG_CTRL_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr_fire) begin
      case (paddr)
        ADDR_CU_CTRL: cu_ctrl_q <= pwdata[15:0];
        ADDR_GIG_CTRL: gig_ctrl_q <= pwdata[3:0];
        ADDR_IRQ_MASK: irq_mask_q <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Link changes and PoE trouble onset are the interrupt events
  always_comb begin
    irq_ev = {trouble, link_now} ^ link_prev_q;
    irq_ev[ST_TROUBLE] = trouble & ~link_prev_q[ST_TROUBLE];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      link_prev_q <= '0;
    end else if (clk_en) begin
      link_prev_q <= {trouble, link_now};
      if (wr_fire && paddr == ADDR_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
    end
  end

  always_comb begin
    status_word = '0;
    status_word[ST_CU_LSB +: N_CU] = link_now[ACT_CU +: N_CU];
    status_word[ST_FX_LSB +: N_FX] = link_now[ACT_FX +: N_FX];
    status_word[ST_GC_LSB +: N_GC] = link_now[ACT_GC +: N_GC];
    status_word[ST_GF_LSB +: N_GF] = link_now[ACT_GF +: N_GF];
    status_word[ST_TROUBLE] = trouble;
    status_word[ST_PD_LSB +: N_CU] = poe_pwr_en;
    status_word[ST_CU100_LSB +: N_CU] = cu_mode_100;
    status_word[ST_CUFULL_LSB +: N_CU] = cu_mode_full;
  end

  // ----------------------------------------
  // APB answer, one wait state
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= acc && !pready;
      if (acc && !pready) begin
        pslverr <= 1'b0;
        case (paddr)
          ADDR_CU_CTRL: prdata <= {16'h0000, cu_ctrl_q};
          ADDR_GIG_CTRL: prdata <= {28'h0000000, gig_ctrl_q};
          ADDR_STATUS: prdata <= status_word;
          ADDR_IRQ_STAT: prdata <= {19'h00000, irq_stat_q};
          ADDR_IRQ_MASK: prdata <= {19'h00000, irq_mask_q};
          default: begin
            prdata <= '0;
            pslverr <= 1'b1;
          end
        endcase
      end else begin
        prdata <= '0;
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Interrupt line
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------
  // Copper, gigabit copper and gigabit fibre negotiation control
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cu_an_en <= '0;
      automatic_crossover <= '0;
      cu_mode_100 <= '0;
      cu_mode_full <= '0;
      gc_auto <= '0;
      gf_auto <= '0;
    end else if (clk_en) begin
      cu_an_en <= ~cu_ctrl_q[CU_AN_DIS_LSB +: N_CU];
      automatic_crossover <= ~cu_ctrl_q[CU_AX_DIS_LSB +: N_CU];
      gc_auto <= ~gig_ctrl_q[GC_MAN_LSB +: N_GC];
      gf_auto <= ~gig_ctrl_q[GF_MAN_LSB +: N_GF];
      for (int i = 0; i < N_CU; i++) begin
        if (cu_ctrl_q[CU_AN_DIS_LSB+i]) begin
          cu_mode_100[i] <= cu_ctrl_q[CU_F100_LSB+i];
          cu_mode_full[i] <= cu_ctrl_q[CU_FFULL_LSB+i];
        end else if (cu_q[i].partner_an) begin
          cu_mode_100[i] <= cu_q[i].partner_100;
          cu_mode_full[i] <= cu_q[i].partner_full;
        end else begin
          cu_mode_100[i] <= cu_q[i].idle_100;
          cu_mode_full[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Lamps and PoE power
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cu_led <= '0;
      fx_la_led <= '0;
      fx_fd_led <= '0;
      gf_led <= '0;
      gc_led_top <= '0;
      gc_led_bot <= '0;
    end else if (clk_en) begin
      // Lamps follow link, receive, fibre duplex and gigabit speed only; PoE state never enters here
      for (int i = 0; i < N_CU; i++) begin
        cu_led[i] <= lamp(cu_q[i].link, blinking_q[ACT_CU+i], dark_q);
      end
      for (int i = 0; i < N_FX; i++) begin
        fx_la_led[i] <= lamp(fx_q[i].link, blinking_q[ACT_FX+i], dark_q);
        fx_fd_led[i] <= fx_q[i].link & fx_q[i].full;
      end
      for (int i = 0; i < N_GF; i++) begin
        gf_led[i] <= lamp(gf_q[i].link, blinking_q[ACT_GF+i], dark_q);
      end
      for (int i = 0; i < N_GC; i++) begin
        case (gc_q[i].speed)
          SPD_1000: begin
            gc_led_top[i] <= lamp(gc_q[i].link, blinking_q[ACT_GC+i], dark_q);
            gc_led_bot[i] <= 1'b0;
          end
          SPD_10: begin
            gc_led_top[i] <= 1'b0;
            gc_led_bot[i] <= lamp(gc_q[i].link, blinking_q[ACT_GC+i], dark_q);
          end
          SPD_100: begin
            gc_led_top[i] <= lamp(gc_q[i].link, blinking_q[ACT_GC+i], dark_q);
            gc_led_bot[i] <= lamp(gc_q[i].link, blinking_q[ACT_GC+i], dark_q);
          end
          default: begin
            gc_led_top[i] <= 1'b0;
            gc_led_bot[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poe_pwr_en <= '0;
      pd_led <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < N_CU; i++) begin
        poe_pwr_en[i] <= pin_ok_q & poe_q[i].sig_ok;
        if (trouble) begin
          pd_led[i] <= 1'b1;
        end else begin
          pd_led[i] <= poe_pwr_en[i] & poe_q[i].drawing;
        end
      end
    end
  end

endmodule

// File: testbench/pd_model.sv
// Powered-device stand-in for the PoE port side.
// Assumes the bench drives which ports carry a valid signature.
`timescale 1ns/100ps
module pd_model (
  input wire logic pclk, // Clock
  input wire logic [3:0] sig_ok, // Valid signature per port
  input wire logic [3:0] pwr_en, // Power sourced by the switch
  output led_ctrl_pkg::poe_port_t [3:0] poe // Detection pins
);
  // ----------------------------------------
  // Draw only while power is sourced
  // ----------------------------------------
  always_ff @(posedge pclk) begin
    for (int i = 0; i < 4; i++) begin
      poe[i].sig_ok <= sig_ok[i];
      poe[i].drawing <= pwr_en[i] & sig_ok[i];
    end
  end
endmodule

// File: testbench/led_ctrl_sva.sv
// Concurrent checks on the lamp controller ports.
// Assumes one pclk domain; bound from the bench top.
`timescale 1ns/100ps
module led_ctrl_sva
  import led_ctrl_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic [7:0] paddr, // Address
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire fibre100_t [3:0] fx_phy, // Fibre status
  input wire gig_cu_t [1:0] gc_phy, // Gig copper status
  input wire logic poe_input_ok, // PoE input power
  input wire logic [3:0] pd_led, // PD lamps
  input wire logic [3:0] poe_pwr_en, // Power enables
  input wire logic [3:0] fx_fd_led, // Duplex lamps
  input wire logic [1:0] gc_led_top, // Upper lamps
  input wire logic [1:0] gc_led_bot, // Lower lamps
  input wire logic [3:0] cu_an_en, // Negotiation enables
  input wire logic [1:0] gc_auto, // Gig copper auto
  input wire logic [1:0] gf_auto // Gig fibre auto
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Bus and lamp relations
  // ----------------------------------------
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0))
    else $error("error flag wrong for address");
  a_gc_upper: assert property (gc_led_top[0] |-> $past(gc_phy[0].link, 3) &&
    ($past(gc_phy[0].speed, 3) == SPD_1000 || $past(gc_phy[0].speed, 3) == SPD_100))
    else $error("upper lamp lit at wrong speed");
  a_gc_lower: assert property (gc_led_bot[0] |-> $past(gc_phy[0].link, 3) &&
    ($past(gc_phy[0].speed, 3) == SPD_10 || $past(gc_phy[0].speed, 3) == SPD_100))
    else $error("lower lamp lit at wrong speed");
  a_trouble_all: assert property (!poe_input_ok [*5] |-> pd_led == 4'hf && poe_pwr_en == 4'h0)
    else $error("trouble indication wrong");
  a_pd_powered: assert property (poe_input_ok [*6] |-> (pd_led & ~$past(poe_pwr_en)) == 4'h0)
    else $error("PD lamp without power");
  a_auto_reset: assert property ($rose(presetn) |=> cu_an_en == 4'hf && gc_auto == 2'h3 && gf_auto == 2'h3)
    else $error("auto modes not set after reset");
  for (genvar i = 0; i < 4; i++) begin : g_fd
    a_duplex_lamp: assert property (fx_fd_led[i] == ($past(fx_phy[i].link, 3) && $past(fx_phy[i].full, 3)))
      else $error("duplex lamp wrong");
  end
endmodule

// File: testbench/tb_top.sv
// Self-checking bench of the port status lamp controller.
// Assumes APB at 250 MHz and a PoE device model on the far side.
`timescale 1ns/100ps
module tb_top;
  import led_ctrl_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, poe_input_ok, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  copper_phy_t [3:0] cu_phy;
  fibre100_t [3:0] fx_phy;
  gig_cu_t [1:0] gc_phy;
  gig_fx_t [1:0] gf_phy;
  poe_port_t [3:0] poe_in;
  logic [3:0] cu_led, pd_led, poe_pwr_en, fx_la_led, fx_fd_led, cu_an_en, automatic_crossover;
  logic [3:0] cu_mode_100, cu_mode_full, sig_ok, m_lk, m_fd;
  logic [1:0] gc_led_top, gc_led_bot, gf_led, gc_auto, gf_auto, m_gl;
  int num_errors, samples_checked, cycles, dk_fx, dk_gf;
  port_status_led_controller #(.BLINK_HALF(8)) i_dut (.*);
  pd_model i_pd (.pclk(pclk), .sig_ok(sig_ok), .pwr_en(poe_pwr_en), .poe(poe_in));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(string n, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cyc(int n);
    repeat (n) @(posedge pclk);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop;
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cu_phy = '0;
    fx_phy = '0;
    gc_phy = '0;
    gf_phy = '0;
    sig_ok = 4'h0;
    poe_input_ok = 1'b1;
    void'($urandom(32'h9311));
    cyc(6);
    presetn <= 1'b1;
    apb(0, ADDR_CU_CTRL, 0);
    chk("cu_ctrl", rd, 32'(CU_CTRL_RST));
    apb(0, ADDR_GIG_CTRL, 0);
    chk("gig_ctrl", rd, 32'(GIG_CTRL_RST));
    apb(0, ADDR_IRQ_MASK, 0);
    chk("irq_mask", rd, 32'(IRQ_MASK_RST));
    apb(0, ADDR_IRQ_STAT, 0);
    chk("irq_stat", rd, 0);
    chk("pd reset", pd_led, 0);
    chk("auto modes", {cu_an_en, automatic_crossover, gc_auto, gf_auto}, 32'hfff);
    apb(0, 8'h14, 0);
    chk("unmapped err", er, 1);
    chk("unmapped data", rd, 0);
    $display("test reset done");
    cu_phy[1] <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    cu_phy[2] <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    apb(1, ADDR_CU_CTRL, 32'h1111);
    cyc(5);
    chk("an_en", cu_an_en, 4'he);
    chk("xover", automatic_crossover, 4'he);
    chk("mode100", cu_mode_100, 4'h3);
    chk("modefull", cu_mode_full, 4'h5);
    chk("cu lamp", cu_led, 4'h6);
    apb(0, ADDR_STATUS, 0);
    chk("status mode", rd[27:20], 8'h53);
    apb(1, ADDR_GIG_CTRL, 32'h6);
    cyc(2);
    chk("gig auto", {gc_auto, gf_auto}, 4'h9);
    apb(1, ADDR_GIG_CTRL, 0);
    cyc(2);
    chk("gig auto back", {gc_auto, gf_auto}, 4'hf);
    $display("test copper done");
    for (int s = 0; s < 4; s++) begin
      gc_phy[0] <= '{1'b1, 2'(s), 1'b0};
      cyc(5);
      chk("gc top", gc_led_top[0], s == 1 || s == 2);
      chk("gc bot", gc_led_bot[0], s == 0 || s == 1);
    end
    $display("test speed done");
    repeat (4) begin
      m_lk = 4'($urandom);
      m_fd = 4'($urandom);
      m_gl = 2'($urandom);
      for (int i = 0; i < 4; i++) begin
        fx_phy[i] <= '{m_lk[i], m_fd[i], 1'b0};
        cu_phy[i].link <= m_fd[i];
      end
      for (int i = 0; i < 2; i++) gf_phy[i] <= '{m_gl[i], 1'b0};
      cyc(5);
      chk("cu lamp", cu_led, m_fd);
      chk("fx lamp", fx_la_led, m_lk);
      chk("fx duplex", fx_fd_led, m_lk & m_fd);
      chk("gf lamp", gf_led, m_gl);
      apb(0, ADDR_STATUS, 0);
      chk("status link", rd[11:0], {m_gl, 2'b01, m_lk, m_fd});
    end
    $display("test lamps done");
    fx_phy[0] <= '{1'b1, 1'b0, 1'b1};
    gf_phy[0] <= '{1'b1, 1'b1};
    cu_phy[0].link <= 1'b1;
    cu_phy[0].rx_act <= 1'b1;
    repeat (64) begin
      @(posedge pclk);
      dk_fx += (fx_la_led[0] === 1'b0);
      dk_gf += (gf_led[0] === 1'b0);
    end
    chk("fx blink", dk_fx > 0 && dk_fx < 60, 1);
    chk("gf blink", dk_gf > 0 && dk_gf < 60, 1);
    fx_phy[0].rx_act <= 1'b0;
    gf_phy[0].rx_act <= 1'b0;
    cu_phy[0].rx_act <= 1'b0;
    cyc(48);
    dk_fx = 0;
    repeat (32) begin
      @(posedge pclk);
      dk_fx += (fx_la_led[0] !== 1'b1) + (gf_led[0] !== 1'b1) + (cu_led[0] !== 1'b1);
    end
    chk("steady lamps", dk_fx, 0);
    $display("test blink done");
    sig_ok <= 4'h5;
    cyc(14);
    chk("pwr en", poe_pwr_en, 4'h5);
    chk("pd lamp", pd_led, 4'h5);
    poe_input_ok <= 1'b0;
    cyc(6);
    chk("trouble lamps", pd_led, 4'hf);
    chk("trouble pwr", poe_pwr_en, 4'h0);
    chk("data lamps", cu_led, {m_fd[3:1], 1'b1});
    apb(0, ADDR_STATUS, 0);
    chk("status trouble", rd[ST_TROUBLE], 1);
    poe_input_ok <= 1'b1;
    cyc(14);
    chk("pd lamp back", pd_led, 4'h5);
    $display("test poe done");
    apb(1, ADDR_IRQ_STAT, 32'h1fff);
    apb(1, ADDR_IRQ_MASK, 32'h10);
    cyc(2);
    chk("irq idle", irq, 0);
    fx_phy[0].link <= 1'b0;
    cyc(6);
    chk("irq set", irq, 1);
    apb(0, ADDR_IRQ_STAT, 0);
    chk("irq stat", rd[12:0], 13'h0010);
    apb(1, ADDR_IRQ_MASK, 0);
    cyc(2);
    chk("irq masked", irq, 0);
    apb(1, ADDR_IRQ_MASK, 32'h10);
    cyc(2);
    chk("irq unmasked", irq, 1);
    apb(1, ADDR_STATUS, 32'hffffffff);
    chk("status write err", er, 0);
    apb(1, ADDR_IRQ_STAT, 32'h10);
    cyc(2);
    chk("irq cleared", irq, 0);
    $display("test irq done");
    clk_en <= 1'b0;
    cu_phy[3].link <= !m_fd[3];
    cyc(6);
    chk("frozen lamp", cu_led[3], m_fd[3]);
    clk_en <= 1'b1;
    cyc(5);
    chk("thawed lamp", cu_led[3], !m_fd[3]);
    $display("test freeze done");
    report_and_stop;
  end
endmodule
bind port_status_led_controller led_ctrl_sva i_sva (.*);
